/* rtl/tbfs_mem_if.sv */
// Port bundle between the parser and the status word memory
`timescale 1ns/1ps
`default_nettype none
interface tbfs_mem_if;
  import tbfs_pkg::*;
  logic             wr_en;
  logic [SF_AW-1:0] wr_addr;
  logic [31:0]      wr_data;
  logic [SF_AW-1:0] rd_addr;
  logic [31:0]      rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

/* rtl/tbfs_pkg.sv */
// Constants, field layouts and types of the transmit buffer parser
package tbfs_pkg;

  // Register byte offsets
  localparam int          ADDR_W     = 4;
  localparam logic [3:0]  REG_DATA   = 4'h0;
  localparam logic [3:0]  REG_STAT   = 4'h4;
  localparam logic [3:0]  REG_CFG    = 4'h8;
  localparam logic [3:0]  REG_INFO   = 4'hC;

  // Control and info bits
  localparam int          CFG_DISC   = 0;
  localparam int          CFG_DEFER  = 1;
  localparam int          INFO_USED  = 0;
  localparam int          INFO_TXE   = 8;
  localparam int          INFO_OVR   = 9;
  localparam int          INFO_SUSP  = 10;

  // First command word layout
  localparam int          A_SIZE_LSB = 0;
  localparam int          SIZE_W     = 11;
  localparam int          A_LS_BIT   = 12;
  localparam int          A_FS_BIT   = 13;
  localparam int          A_OFF_LSB  = 16;
  localparam int          OFF_W      = 6;
  localparam int          A_ALN_LSB  = 24;
  localparam logic [1:0]  ALN_16     = 2'h1;
  localparam logic [1:0]  ALN_32     = 2'h2;
  localparam logic [12:0] MASK_4     = 13'h0003;
  localparam logic [12:0] MASK_16    = 13'h000F;
  localparam logic [12:0] MASK_32    = 13'h001F;

  // Second command word layout
  localparam int          B_LEN_LSB  = 0;
  localparam int          B_TAG_LSB  = 16;
  localparam int          TAG_W      = 16;

  // Status word bit positions
  localparam int          ST_TAG_LSB = 16;
  localparam int          ST_ES      = 15;
  localparam int          ST_LOSS    = 11;
  localparam int          ST_NOCAR   = 10;
  localparam int          ST_LATE    = 9;
  localparam int          ST_EXCOL   = 8;
  localparam int          ST_CC_LSB  = 3;
  localparam int          ST_EXDEF   = 2;
  localparam int          ST_DEFER   = 0;

  // Status FIFO geometry
  localparam int          SF_AW      = 4;
  localparam logic [4:0]  SF_DEPTH   = 5'h10;

  typedef enum logic [1:0] {ST_CMD_A, ST_CMD_B, ST_BODY} tbfs_state_e;

endpackage

/* rtl/tbfs_stat_mem.sv */
// Status word memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module tbfs_stat_mem
  import tbfs_pkg::*;
(
  // Clock and enable
  input  wire logic clock,
  input  wire logic clk_en,
  // Memory port
  tbfs_mem_if.mem   bus
);

  logic [31:0] store [int'(SF_DEPTH)];

  always_ff @(posedge clock)
  begin
    if (clk_en && bus.wr_en)
    begin
      store[bus.wr_addr] <= bus.wr_data;
    end
  end

  // Read port follows the head pointer on every enabled cycle
  always_ff @(posedge clock)
  begin
    if (clk_en)
    begin
      bus.rd_data <= store[bus.rd_addr];
    end
  end

endmodule
`default_nettype wire

/* rtl/tbfs_top.sv */
// Transmit buffer parser and status word queue
`timescale 1ns/1ps
`default_nettype none
module tbfs_top
  import tbfs_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Stream to the MAC interface layer
  output logic      [31:0]       mac_data,
  output logic      [3:0]        mac_be,
  output logic                   mac_valid,
  output logic                   mac_last,
  input  wire logic              mac_ready,
  // Packet completion from the transmitter
  input  wire logic              tx_done,
  input  wire logic              tx_carrier_lost,
  input  wire logic              tx_no_carrier,
  input  wire logic              tx_late_coll,
  input  wire logic              tx_excess_coll,
  input  wire logic [3:0]        tx_coll_count,
  input  wire logic              tx_excess_defer,
  input  wire logic              tx_deferred,
  // Transmitter hold
  output logic                   tx_suspend
);

  tbfs_state_e      st;
  logic             wait_q;
  logic             ack;
  logic             data_wr;
  logic             go;
  // Buffer context
  logic [SIZE_W-1:0] size;
  logic [SIZE_W-1:0] rem;
  logic [SIZE_W-1:0] pos;
  logic [SIZE_W-1:0] total_w;
  logic [3:0]        skip;
  logic [1:0]        lane0;
  logic              fs;
  logic              ls;
  logic [31:0]       cmd_b;
  logic [11:0]       sum;
  logic [11:0]       next_sum;
  logic [11:0]       sum_now;
  logic [31:0]       b_now;
  logic [TAG_W-1:0]  pend_tag;
  // Word steering
  logic [1:0]        lane;
  logic [2:0]        avail;
  logic [2:0]        take;
  logic [3:0]        be;
  logic              fwd;
  logic              last_w;
  logic              buf_end;
  logic              len_err;
  logic              b_err;
  // Status queue
  tbfs_mem_if        mem_bus ();
  logic [SF_AW-1:0]  wr_ptr;
  logic [SF_AW-1:0]  rd_ptr;
  logic [4:0]        count;
  logic              head_ok;
  logic              ovr;
  logic              full;
  logic              push;
  logic              pop;
  logic              st_err;
  logic [31:0]       stat_word;
  logic              es;
  // Software view
  logic              cfg_disc;
  logic              cfg_defer;
  logic              transmit_error_flag;

  // Words in the host's data region, padding included
  function automatic logic [SIZE_W-1:0] buf_words(input logic [31:0] a);
    logic [12:0] span;
    logic [12:0] amask;
    amask = (a[A_ALN_LSB +: 2] == ALN_32) ? MASK_32 :
            (a[A_ALN_LSB +: 2] == ALN_16) ? MASK_16 : MASK_4;
    span  = 13'(a[A_OFF_LSB +: OFF_W]) + 13'(a[A_SIZE_LSB +: SIZE_W]);
    span  = (span + amask) & ~amask;
    return span[12:2];
  endfunction

  always_comb
  begin
    lane     = (pos == SIZE_W'(skip)) ? lane0 : 2'h0;
    avail    = 3'h4 - 3'(lane);
    take     = (rem < SIZE_W'(avail)) ? rem[2:0] : avail;
    be       = 4'(((5'h01 << take) - 5'h01) << lane);
    fwd      = (st == ST_BODY) && (pos >= SIZE_W'(skip))
               && (rem != '0);
    last_w   = (pos == total_w - SIZE_W'(1));
    go       = !(fwd && mac_valid && !mac_ready);
    next_sum = (fs ? 12'h000 : sum) + 12'(size);
    sum_now  = (st == ST_CMD_B) ? next_sum : sum;
    b_now    = (st == ST_CMD_B) ? avs_writedata : cmd_b;
  end

  // Bus handshake: one wait cycle (more while a data write waits on a stalled stream), then a one-cycle answer
  assign ack = wait_q && (avs_read || avs_write)
               && !(avs_write && avs_address == REG_DATA && !go);
  assign data_wr = ack && avs_write && (avs_address == REG_DATA);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wait_q <= 1'b1;
    end
    else if (clk_en)
    begin
      wait_q <= !ack;
    end
  end

  always_comb
  begin
    buf_end = data_wr && (((st == ST_CMD_B) && (total_w == '0))
              || ((st == ST_BODY) && last_w));
    len_err = buf_end && ls
              && (sum_now != 12'(b_now[B_LEN_LSB +: SIZE_W]));
    b_err   = data_wr && (st == ST_CMD_B) && !fs
              && (avs_writedata != cmd_b);
  end

  // Buffer parser
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st      <= ST_CMD_A;
      size    <= '0;
      rem     <= '0;
      pos     <= '0;
      total_w <= '0;
      skip    <= 4'h0;
      lane0   <= 2'h0;
      fs      <= 1'b0;
      ls      <= 1'b0;
      cmd_b   <= 32'h0000_0000;
      sum     <= 12'h000;
    end
    else if (clk_en && data_wr)
    begin
      case (st)
        ST_CMD_A:
        begin
          size    <= avs_writedata[A_SIZE_LSB +: SIZE_W];
          fs      <= avs_writedata[A_FS_BIT];
          ls      <= avs_writedata[A_LS_BIT];
          skip    <= avs_writedata[A_OFF_LSB + 2 +: 4];
          lane0   <= avs_writedata[A_OFF_LSB +: 2];
          total_w <= buf_words(avs_writedata);
          st      <= ST_CMD_B;
        end
        ST_CMD_B:
        begin
          cmd_b <= avs_writedata;
          sum   <= next_sum;
          rem   <= size;
          pos   <= '0;
          st    <= (total_w == '0) ? ST_CMD_A : ST_BODY;
        end
        ST_BODY:
        begin
          pos <= pos + SIZE_W'(1);
          if (fwd)
          begin
            rem <= rem - SIZE_W'(take);
          end
          if (last_w)
          begin
            st <= ST_CMD_A;
          end
        end
        default:
        begin
          st <= ST_CMD_A;
        end
      endcase
    end
  end

  // Packet tag held until the transmitter reports
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_tag <= '0;
    end
    else if (clk_en && buf_end && ls)
    begin
      pend_tag <= b_now[B_TAG_LSB +: TAG_W];
    end
  end

  // Only payload lanes reach the MAC side
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mac_valid <= 1'b0;
      mac_data  <= 32'h0000_0000;
      mac_be    <= 4'h0;
      mac_last  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (data_wr && fwd)
      begin
        mac_valid <= 1'b1;
        mac_data  <= avs_writedata;
        mac_be    <= be;
        mac_last  <= ls && (rem == SIZE_W'(take));
      end
      else if (mac_ready)
      begin
        mac_valid <= 1'b0;
      end
    end
  end

  // Status word assembly
  always_comb
  begin
    es = tx_carrier_lost || tx_no_carrier || tx_late_coll
         || tx_excess_coll || (tx_excess_defer && cfg_defer);
    stat_word = 32'h0000_0000;
    stat_word[ST_TAG_LSB +: TAG_W] = pend_tag;
    stat_word[ST_ES]    = es;
    stat_word[ST_LOSS]  = tx_carrier_lost;
    stat_word[ST_NOCAR] = tx_no_carrier;
    stat_word[ST_LATE]  = tx_late_coll;
    stat_word[ST_EXCOL] = tx_excess_coll;
    stat_word[ST_CC_LSB +: 4] = tx_coll_count;
    stat_word[ST_EXDEF] = tx_excess_defer && cfg_defer;
    stat_word[ST_DEFER] = tx_deferred;
  end

  always_comb
  begin
    full   = (count == SF_DEPTH);
    pop    = ack && avs_read && (avs_address == REG_STAT) && head_ok;
    push   = tx_done && !ovr && !full;
    st_err = tx_done && full && !cfg_disc;
  end

  assign mem_bus.wr_en   = push && clk_en;
  assign mem_bus.wr_addr = wr_ptr;
  assign mem_bus.wr_data = stat_word;
  assign mem_bus.rd_addr = rd_ptr;

  tbfs_stat_mem u_mem (
    .clock  (clock),
    .clk_en (clk_en),
    .bus    (mem_bus.mem)
  );

  // Queue pointers advance in completion order
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      count   <= 5'h00;
      head_ok <= 1'b0;
    end
    else if (clk_en)
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + SF_AW'(1);
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + SF_AW'(1);
      end
      count   <= count + 5'(push) - 5'(pop);
      // Memory read lags a write by one cycle
      head_ok <= (count != 5'h00);
    end
  end

  // Overrun latch: set wins over a freeing read
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ovr <= 1'b0;
    end
    else if (clk_en)
    begin
      if (tx_done && full && cfg_disc)
      begin
        ovr <= 1'b1;
      end
      else if (pop)
      begin
        ovr <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_suspend <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_suspend <= (count + 5'(push) - 5'(pop) == SF_DEPTH)
                    && !cfg_disc;
    end
  end

  // Configuration
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_disc  <= 1'b0;
      cfg_defer <= 1'b0;
    end
    else if (clk_en && ack && avs_write && avs_address == REG_CFG)
    begin
      cfg_disc  <= avs_writedata[CFG_DISC];
      cfg_defer <= avs_writedata[CFG_DEFER];
    end
  end

  // Sticky error, write one to clear, a new error wins
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      transmit_error_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      if (len_err || b_err || st_err)
      begin
        transmit_error_flag <= 1'b1;
      end
      else if (ack && avs_write && avs_address == REG_INFO
               && avs_writedata[INFO_TXE])
      begin
        transmit_error_flag <= 1'b0;
      end
    end
  end

  // Read data stand from the answer edge until the next read answer
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (clk_en && ack && avs_read)
    begin
      avs_readdata <= 32'h0000_0000;
      case (avs_address)
        REG_STAT:
        begin
          avs_readdata <= head_ok ? mem_bus.rd_data : 32'h0000_0000;
        end
        REG_CFG:
        begin
          avs_readdata[CFG_DISC]  <= cfg_disc;
          avs_readdata[CFG_DEFER] <= cfg_defer;
        end
        REG_INFO:
        begin
          avs_readdata[INFO_USED +: 5] <= ovr ? 5'h00 : count;
          avs_readdata[INFO_TXE]  <= transmit_error_flag;
          avs_readdata[INFO_OVR]  <= ovr;
          avs_readdata[INFO_SUSP] <= tx_suspend;
        end
        default:
        begin
          avs_readdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign avs_waitrequest = wait_q;

endmodule
`default_nettype wire

/* tb/tbfs_mac_model.sv */
// MAC side sink that logs forwarded words
`timescale 1ns/1ps
`default_nettype none
module tbfs_mac_model (
  // Clock, reset, pace
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        fast,
  // Stream
  input  wire logic [31:0] mac_data,
  input  wire logic [3:0]  mac_be,
  input  wire logic        mac_valid,
  input  wire logic        mac_last,
  output logic             mac_ready
);
  logic [36:0] log_q [0:31];
  int          n;
  logic [1:0]  ph;
  // Slow pace is ready one cycle in three to stall the parser
  assign mac_ready = fast || ph == 2'h0;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      ph <= 2'h0;
      n <= 0;
    end
    else
    begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (mac_valid && mac_ready)
      begin
        log_q[n[4:0]] <= {mac_last, mac_be, mac_data};
        n <= n + 1;
      end
    end
endmodule
`default_nettype wire

/* tb/tbfs_sva.sv */
// Assertion checker for the transmit buffer parser ports
`timescale 1ns/1ps
`default_nettype none
module tbfs_sva
  import tbfs_pkg::*;
(
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst_b,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  // Stream and completion
  input wire logic [31:0]       mac_data,
  input wire logic [3:0]        mac_be,
  input wire logic              mac_valid,
  input wire logic              mac_ready,
  input wire logic              tx_done,
  input wire logic              tx_suspend
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence stat_ans;
    avs_read && avs_address == REG_STAT && avs_waitrequest ##1
      !avs_waitrequest;
  endsequence
  mac_hold_a: assert property (mac_valid && !mac_ready |=>
    mac_valid && $stable(mac_data) && $stable(mac_be))
    else $error("stream word changed while stalled");
  be_some_a: assert property (mac_valid |-> mac_be != 4'h0)
    else $error("word forwarded with no lanes");
  be_contig_a: assert property (mac_valid |-> mac_be inside
    {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF})
    else $error("lanes not contiguous");
  fwd_cause_a: assert property ($rose(mac_valid) |->
    $past(avs_write && avs_address == REG_DATA && avs_waitrequest))
    else $error("word forwarded without a data write");
  susp_cause_a: assert property ($rose(tx_suspend) |-> $past(tx_done))
    else $error("hold raised without completion");
  susp_free_a: assert property ($fell(tx_suspend) |->
    $past(avs_read || avs_write))
    else $error("hold dropped without host access");
  stat_resvd_a: assert property (stat_ans |->
    avs_readdata[14:12] == 3'h0 && !avs_readdata[7] && !avs_readdata[1])
    else $error("reserved status bits set");
  stat_sum_a: assert property (stat_ans |->
    avs_readdata[15] == |{avs_readdata[11:8], avs_readdata[2]})
    else $error("summary bit wrong");
endmodule
bind tbfs_top tbfs_sva u_sva (.clock(clock), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .mac_data(mac_data), .mac_be(mac_be), .mac_valid(mac_valid),
  .mac_ready(mac_ready), .tx_done(tx_done), .tx_suspend(tx_suspend));
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the transmit buffer parser
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tbfs_pkg::*;
  logic              clock;
  logic              rst_b;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [31:0]       mac_data;
  logic [3:0]        mac_be;
  logic              mac_valid;
  logic              mac_last;
  logic              mac_ready;
  logic              fast;
  logic              clk_en;
  logic              tx_done;
  logic [9:0]        res;
  logic              tx_suspend;
  logic [31:0]       rd;
  int                failures;
  int                checks;
  int                base;
  int                i;
  int                rb [5] = '{9, 8, 7, 6, 1};
  int                sb [5] = '{11, 10, 9, 8, 2};
  tbfs_top u_dut (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mac_data(mac_data),
    .mac_be(mac_be), .mac_valid(mac_valid), .mac_last(mac_last),
    .mac_ready(mac_ready), .tx_done(tx_done), .tx_carrier_lost(res[9]),
    .tx_no_carrier(res[8]), .tx_late_coll(res[7]),
    .tx_excess_coll(res[6]), .tx_coll_count(res[5:2]),
    .tx_excess_defer(res[1]), .tx_deferred(res[0]),
    .tx_suspend(tx_suspend));
  tbfs_mac_model u_mac (.clock(clock), .rst_b(rst_b), .fast(fast),
    .mac_data(mac_data), .mac_be(mac_be), .mac_valid(mac_valid),
    .mac_last(mac_last), .mac_ready(mac_ready));
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task chk(input logic [36:0] got, input logic [36:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 500);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      failures++;
      close_out();
    end
  endtask
  task done(input logic [9:0] r);
    @(posedge clock);
    tx_done <= 1'b1;
    res <= r;
    @(posedge clock);
    tx_done <= 1'b0;
    @(posedge clock);
  endtask
  // Bounded wait for the sink to log a word count
  task drain(input int want);
    for (int k = 0; k < 300 && u_mac.n < want; k++)
      @(posedge clock);
    chk(u_mac.n, want);
    if (u_mac.n != want)
      close_out();
  endtask
  initial
  begin
    rst_b = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    tx_done = 1'b0;
    res = 10'h0;
    fast = 1'b0;
    clk_en = 1'b1;
    failures = 0;
    checks = 0;
    repeat (16) @(posedge clock);
    chk({avs_waitrequest, mac_valid, tx_suspend}, 3'h4);
    rst_b <= 1'b1;
    bus(1'b1, REG_DATA, 32'h0106_3005);
    bus(1'b1, REG_DATA, 32'hA5C3_0005);
    bus(1'b1, REG_DATA, 32'h1111_1111);
    bus(1'b1, REG_DATA, 32'h4433_2211);
    bus(1'b1, REG_DATA, 32'h8877_6655);
    bus(1'b1, REG_DATA, 32'hCCBB_AA99);
    drain(2);
    chk(u_mac.log_q[0], {1'b0, 4'hC, 32'h4433_2211});
    chk(u_mac.log_q[1], {1'b1, 4'h7, 32'h8877_6655});
    done(10'b1000_0011_01);
    bus(1'b0, REG_STAT, 32'h0);
    chk(rd, 32'hA5C3_8819);
    bus(1'b1, REG_CFG, 32'h2);
    for (i = 0; i < 5; i++)
    begin
      done(10'h1 << rb[i]);
      bus(1'b0, REG_STAT, 32'h0);
      chk(rd, {16'hA5C3, 16'h8000 | (16'h1 << sb[i])});
    end
    bus(1'b1, REG_CFG, 32'h0);
    done(10'h2);
    bus(1'b0, REG_STAT, 32'h0);
    chk(rd, 32'hA5C3_0000);
    // A completion while frozen must leave the queue untouched
    clk_en <= 1'b0;
    done(10'h1);
    clk_en <= 1'b1;
    bus(1'b0, REG_INFO, 32'h0);
    chk(rd, 32'h0);
    fast <= 1'b1;
    base = u_mac.n;
    bus(1'b1, REG_DATA, 32'h021F_3005);
    bus(1'b1, REG_DATA, 32'h0007_0004);
    for (i = 0; i < 16; i++)
      bus(1'b1, REG_DATA, {4{i[7:0]}});
    drain(base + 2);
    chk(u_mac.log_q[base], {1'b0, 4'h8, 32'h0707_0707});
    chk(u_mac.log_q[base + 1], {1'b1, 4'hF, 32'h0808_0808});
    bus(1'b0, REG_INFO, 32'h0);
    chk(rd, 32'h100);
    bus(1'b1, REG_INFO, 32'h100);
    bus(1'b0, REG_INFO, 32'h0);
    chk(rd, 32'h0);
    for (i = 0; i < 17; i++)
      done({4'h0, i[3:0], 2'h0});
    chk(tx_suspend, 1'b1);
    bus(1'b0, REG_INFO, 32'h0);
    chk(rd, 32'h510);
    for (i = 0; i < 16; i++)
    begin
      bus(1'b0, REG_STAT, 32'h0);
      chk(rd[6:3], i[3:0]);
    end
    chk(tx_suspend, 1'b0);
    bus(1'b1, REG_INFO, 32'h100);
    bus(1'b1, REG_CFG, 32'h1);
    for (i = 0; i < 17; i++)
      done({4'h0, i[3:0], 2'h0});
    chk(tx_suspend, 1'b0);
    bus(1'b0, REG_INFO, 32'h0);
    chk(rd, 32'h200);
    bus(1'b0, REG_STAT, 32'h0);
    chk(rd[6:3], 4'h0);
    close_out();
  end
endmodule
`default_nettype wire
